// ==== include/sxa_pkg.sv ====
package sxa_pkg;

    // ------------------------------------------------------------
    // Widths and operand limits
    // ------------------------------------------------------------
    localparam int DATA_W = 8;          // Datapath width
    localparam int ADDR_W = 7;          // File address width
    localparam logic [6:0] FILE_ADDR_MAX = 7'h7f;   // Highest file address
    localparam logic [6:0] DIR_SEL_A = 7'h05;       // Direction register of port A
    localparam logic [6:0] DIR_SEL_B = 7'h06;       // Direction register of port B
    localparam logic [6:0] DIR_SEL_C = 7'h07;       // Direction register of port C
    localparam logic [7:0] DIR_RESET = 8'hff;       // Direction registers reset to all inputs
    localparam logic [7:0] W_RESET = 8'h00;         // Working register reset value
    localparam logic DEST_W = 1'b0;                 // Destination select: working register
    localparam logic DEST_FILE = 1'b1;              // Destination select: file register

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE,
        OP_SUB_W_FROM_FILE,
        OP_SUB_W_FROM_FILE_BORROW,
        OP_NIBBLE_EXCHANGE,
        OP_XOR_LITERAL_INTO_W,
        OP_XOR_W_WITH_FILE,
        OP_DIRECTION_LOAD
    } sxa_op_type;

    // Instruction request as decoded upstream
    typedef struct packed {
        logic valid;
        sxa_op_type op;
        logic [6:0] file_addr;
        logic dest;
        logic [7:0] literal;
    } sxa_instr_type;

    // Status flags
    typedef struct packed {
        logic carry;
        logic digit_carry;
        logic zero;
    } sxa_flags_type;

    // File write-back request
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } sxa_file_wr_type;

endpackage : sxa_pkg

// ==== hdl/sxa_alu.sv ====
`timescale 1ns/1ps
// Functional notes
// [RULE1] Subtract: file minus W, file address 0..127
// [RULE2] Carry set when no borrow; digit carry likewise
// [RULE3] Borrow subtract also takes inverted carry; updates C,DC,Z
// [RULE4] Borrow subtract: 0 to W, 1 to file
// [RULE5] Nibble exchange swaps halves; flags untouched
// [RULE6] Nibble exchange: 1 to file, 0 to W
// [RULE7] Literal XOR into W; only zero flag
// [RULE8] Literal XOR always writes W
// [RULE9] File XOR with W; only zero flag
// [RULE10] File XOR, subtract: 1 file, 0 W
// [RULE11] Direction load: 5 A, 6 B, 7 C
// [RULE12] Borrow subtract destination optional, address 0..127
// [RULE13] Zero flag set when result is zero
module sxa_alu (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Decoded instruction and file operand
    input wire sxa_pkg::sxa_instr_type instr,
    input wire logic [7:0] file_rd_data,
    // File write-back
    output sxa_pkg::sxa_file_wr_type file_wr,
    // Core state
    output logic [7:0] w_value,
    output sxa_pkg::sxa_flags_type flags,
    // Port direction registers
    output logic [7:0] port_a_direction,
    output logic [7:0] port_b_direction,
    output logic [7:0] port_c_direction
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] w;
        sxa_pkg::sxa_flags_type flags;
        sxa_pkg::sxa_file_wr_type wr;
        logic [7:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0] dir_c;
    } sxa_state_type;

    sxa_state_type state_reg; // Registered state
    sxa_state_type state_next; // Next state

    // Nine-bit subtract; top bit of the sum is the no-borrow carry
    function automatic logic [8:0] sxa_sub9(input logic [7:0] a, input logic [7:0] b, input logic cin);
        sxa_sub9 = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    endfunction : sxa_sub9

    // Nibble carry with the same carry-in
    function automatic logic sxa_nib_carry(input logic [3:0] a, input logic [3:0] b, input logic cin);
        logic [4:0] s;
        s = {1'b0, a} + {1'b0, ~b} + {4'h0, cin};
        sxa_nib_carry = s[4];
    endfunction : sxa_nib_carry

    logic [8:0] diff; // Subtract result with carry
    logic sub_cin; // One for plain subtract, carry for borrow form
    logic [7:0] result; // Chosen result
    logic write_file; // Result goes to file
    logic has_result; // Set only by ops that produce a value

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.wr.en = 1'b0;
        // Borrow form feeds inverted borrow, which is the carry itself
        sub_cin = (instr.op == sxa_pkg::OP_SUB_W_FROM_FILE_BORROW) ? state_reg.flags.carry : 1'b1; // [RULE3]
        diff = sxa_sub9(file_rd_data, state_reg.w, sub_cin); // [RULE1]
        result = 8'h00;
        write_file = 1'b0;
        // Unknown codes leave this low, so a stray code writes nothing
        has_result = 1'b0;
        if (instr.valid) begin
            case (instr.op)
                sxa_pkg::OP_SUB_W_FROM_FILE, sxa_pkg::OP_SUB_W_FROM_FILE_BORROW: begin
                    result = diff[7:0]; // [RULE1] [RULE3]
                    has_result = 1'b1;
                    write_file = (instr.dest == sxa_pkg::DEST_FILE); // [RULE4] [RULE10] [RULE12]
                    state_next.flags.carry = diff[8]; // [RULE2]
                    state_next.flags.digit_carry =
                        sxa_nib_carry(file_rd_data[3:0], state_reg.w[3:0], sub_cin); // [RULE2]
                    state_next.flags.zero = (diff[7:0] == 8'h00); // [RULE13]
                end
                sxa_pkg::OP_NIBBLE_EXCHANGE: begin
                    // Flags deliberately left alone
                    result = {file_rd_data[3:0], file_rd_data[7:4]}; // [RULE5]
                    has_result = 1'b1;
                    write_file = (instr.dest == sxa_pkg::DEST_FILE); // [RULE6]
                end
                sxa_pkg::OP_XOR_LITERAL_INTO_W: begin
                    result = state_reg.w ^ instr.literal; // [RULE7]
                    has_result = 1'b1;
                    write_file = 1'b0; // [RULE8]
                    state_next.flags.zero = (result == 8'h00); // [RULE7] [RULE13]
                end
                sxa_pkg::OP_XOR_W_WITH_FILE: begin
                    result = state_reg.w ^ file_rd_data; // [RULE9]
                    has_result = 1'b1;
                    write_file = (instr.dest == sxa_pkg::DEST_FILE); // [RULE10]
                    state_next.flags.zero = (result == 8'h00); // [RULE9] [RULE13]
                end
                sxa_pkg::OP_DIRECTION_LOAD: begin
                    // Out-of-range selector loads nothing
                    if (instr.file_addr == sxa_pkg::DIR_SEL_A) begin
                        state_next.dir_a = state_reg.w; // [RULE11]
                    end else if (instr.file_addr == sxa_pkg::DIR_SEL_B) begin
                        state_next.dir_b = state_reg.w; // [RULE11]
                    end else if (instr.file_addr == sxa_pkg::DIR_SEL_C) begin
                        state_next.dir_c = state_reg.w; // [RULE11]
                    end
                end
                default: begin
                    result = 8'h00;
                end
            endcase
            // Route result to one destination only; direction loads, no-ops and
            // undefined codes carry no result and must not disturb W
            if (has_result) begin
                if (write_file) begin
                    state_next.wr.en = 1'b1;
                    state_next.wr.addr = instr.file_addr;
                    state_next.wr.data = result;
                end else begin
                    state_next.w = result;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Synchronous reset from the core reset on this same clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg.w <= sxa_pkg::W_RESET;
            state_reg.flags <= '0;
            state_reg.wr <= '0;
            state_reg.dir_a <= sxa_pkg::DIR_RESET;
            state_reg.dir_b <= sxa_pkg::DIR_RESET;
            state_reg.dir_c <= sxa_pkg::DIR_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flip-flops
    assign file_wr = state_reg.wr;
    assign w_value = state_reg.w;
    assign flags = state_reg.flags;
    assign port_a_direction = state_reg.dir_a;
    assign port_b_direction = state_reg.dir_b;
    assign port_c_direction = state_reg.dir_c;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_sub_issue;
        instr.valid && instr.op == sxa_pkg::OP_SUB_W_FROM_FILE;
    endsequence

    // One sequence per instruction kind; some properties start from these, others test instr directly
    sequence s_borrow_issue;
        instr.valid && instr.op == sxa_pkg::OP_SUB_W_FROM_FILE_BORROW;
    endsequence

    sequence s_swap_issue;
        instr.valid && instr.op == sxa_pkg::OP_NIBBLE_EXCHANGE;
    endsequence

    sequence s_xorl_issue;
        instr.valid && instr.op == sxa_pkg::OP_XOR_LITERAL_INTO_W;
    endsequence

    sequence s_xorf_issue;
        instr.valid && instr.op == sxa_pkg::OP_XOR_W_WITH_FILE;
    endsequence

    sequence s_dir_issue;
        instr.valid && instr.op == sxa_pkg::OP_DIRECTION_LOAD;
    endsequence

    a_sub_carry_flag: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        s_sub_issue |=> flags.carry == ($past(w_value) <= $past(file_rd_data)))
        else $error("carry wrong after subtract");

    a_sub_to_w: assert property (@(posedge clk) disable iff (!rst_n) // [RULE1]
        s_sub_issue ##0 (instr.dest == 1'b0) |=> w_value == 8'($past(file_rd_data) - $past(w_value)))
        else $error("subtract result wrong in W");

    a_borrow_sub_file: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
        instr.valid && instr.op == sxa_pkg::OP_SUB_W_FROM_FILE_BORROW && instr.dest |=>
        file_wr.en && file_wr.data == 8'($past(file_rd_data) - $past(w_value) - 8'(!$past(flags.carry))))
        else $error("borrow subtract file write wrong");

    a_swap_flags_kept: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
        instr.valid && instr.op == sxa_pkg::OP_NIBBLE_EXCHANGE |=> $stable(flags))
        else $error("nibble exchange changed flags");

    a_swap_file: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
        instr.valid && instr.op == sxa_pkg::OP_NIBBLE_EXCHANGE && instr.dest |=>
        file_wr.en && file_wr.data == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
        else $error("nibble exchange write wrong");

    a_xorl_w_only: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
        instr.valid && instr.op == sxa_pkg::OP_XOR_LITERAL_INTO_W |=>
        !file_wr.en && w_value == ($past(w_value) ^ $past(instr.literal)) && $stable(flags.carry))
        else $error("literal xor wrong");

    a_xorf_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
        instr.valid && instr.op == sxa_pkg::OP_XOR_W_WITH_FILE |=>
        flags.zero == ($past(w_value) == $past(file_rd_data)) && $stable(flags.digit_carry))
        else $error("file xor zero flag wrong");

    a_xorf_dest_w: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
        instr.valid && instr.op == sxa_pkg::OP_XOR_W_WITH_FILE && !instr.dest |=> !file_wr.en)
        else $error("file xor wrote file with dest W");

    a_dir_load_b: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        instr.valid && instr.op == sxa_pkg::OP_DIRECTION_LOAD && instr.file_addr == sxa_pkg::DIR_SEL_B |=>
        port_b_direction == $past(w_value) && $stable(port_a_direction) && $stable(flags))
        else $error("direction load wrong");

    a_zero_flag: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
        s_sub_issue |=> flags.zero == ($past(file_rd_data) == $past(w_value)))
        else $error("zero flag wrong after subtract");

    // Borrow form: carry is no-borrow with the old carry as carry-in
    a_borrow_carry: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
        s_borrow_issue |=> flags.carry ==
        ({1'b0, $past(file_rd_data)} >= {1'b0, $past(w_value)} + {8'h00, !$past(flags.carry)}))
        else $error("carry wrong after borrow subtract");

    // Result into W when the select is zero
    a_borrow_to_w: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
        s_borrow_issue ##0 (instr.dest == sxa_pkg::DEST_W) |=> !file_wr.en &&
        w_value == 8'($past(file_rd_data) - $past(w_value) - 8'(!$past(flags.carry))))
        else $error("borrow subtract result wrong in W");

    a_borrow_addr: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
        s_borrow_issue ##0 (instr.dest == sxa_pkg::DEST_FILE) |=>
        file_wr.addr == $past(instr.file_addr) && $stable(w_value))
        else $error("borrow subtract wrote wrong address");

    // Zero flag follows the full eight-bit borrow result
    a_borrow_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RULE13]
        s_borrow_issue |=>
        flags.zero == (8'($past(file_rd_data) - $past(w_value) - 8'(!$past(flags.carry))) == 8'h00))
        else $error("zero flag wrong after borrow subtract");

    // Digit carry mirrors the carry on the low nibbles
    a_sub_digit: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
        s_sub_issue |=> flags.digit_carry == ($past(w_value[3:0]) <= $past(file_rd_data[3:0])))
        else $error("digit carry wrong after subtract");

    a_sub_to_file: assert property (@(posedge clk) disable iff (!rst_n) // [RULE10]
        s_sub_issue ##0 (instr.dest == sxa_pkg::DEST_FILE) |=> file_wr.en &&
        file_wr.addr == $past(instr.file_addr) && $stable(w_value))
        else $error("subtract file write wrong");

    a_swap_to_w: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
        s_swap_issue ##0 (instr.dest == sxa_pkg::DEST_W) |=> !file_wr.en &&
        w_value == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])})
        else $error("nibble exchange result wrong in W");

    a_swap_file_w: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
        s_swap_issue ##0 (instr.dest == sxa_pkg::DEST_FILE) |=>
        file_wr.addr == $past(instr.file_addr) && $stable(w_value))
        else $error("nibble exchange disturbed W");

    // Literal xor leaves carry and digit carry alone
    a_xorl_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
        s_xorl_issue |=> flags.zero == ($past(w_value) == $past(instr.literal)) && $stable(flags.digit_carry))
        else $error("literal xor zero flag wrong");

    a_xorf_file: assert property (@(posedge clk) disable iff (!rst_n) // [RULE9]
        s_xorf_issue ##0 (instr.dest == sxa_pkg::DEST_FILE) |=> file_wr.en &&
        file_wr.data == ($past(w_value) ^ $past(file_rd_data)) && $stable(w_value))
        else $error("file xor write wrong");

    // Each selector touches only its own direction register
    a_dir_load_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        s_dir_issue ##0 (instr.file_addr == sxa_pkg::DIR_SEL_A) |=> port_a_direction == $past(w_value) &&
        $stable(port_b_direction) && $stable(port_c_direction) && $stable(w_value))
        else $error("direction load of port A wrong");

    a_dir_load_c: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        s_dir_issue ##0 (instr.file_addr == sxa_pkg::DIR_SEL_C) |=> port_c_direction == $past(w_value) &&
        $stable(port_a_direction) && $stable(port_b_direction) && $stable(flags))
        else $error("direction load of port C wrong");

    // A selector outside 5..7 must leave every register alone
    a_dir_bad_sel: assert property (@(posedge clk) disable iff (!rst_n) // [RULE11]
        s_dir_issue ##0 (instr.file_addr < sxa_pkg::DIR_SEL_A || instr.file_addr > sxa_pkg::DIR_SEL_C) |=>
        $stable(port_a_direction) && $stable(port_b_direction) && $stable(port_c_direction) && !file_wr.en)
        else $error("direction load with bad selector changed state");

endmodule : sxa_alu

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    // ----------------------------------------
    // Design hookup and reference state
    // ----------------------------------------
    logic clk;
    logic rst_n;
    sxa_pkg::sxa_instr_type instr;
    logic [7:0] file_rd_data;
    sxa_pkg::sxa_file_wr_type file_wr;
    logic [7:0] w_value;
    sxa_pkg::sxa_flags_type flags;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
    int miscompares = 0;
    int checks = 0;
    logic [7:0] ew;    // Expected working register
    logic [2:0] ef;    // Expected carry, digit carry, zero
    logic [7:0] ed [3]; // Expected direction registers
    sxa_alu uut (.clk(clk), .rst_n(rst_n), .instr(instr), .file_rd_data(file_rd_data), .file_wr(file_wr),
        .w_value(w_value), .flags(flags), .port_a_direction(dir_a), .port_b_direction(dir_b),
        .port_c_direction(dir_c));
    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ----------------------------------------
    // Compares and run end
    // ----------------------------------------
    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk8
    task automatic chk3(input string nm, input logic [2:0] e, input logic [2:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %s expected %b seen %b", nm, e, s);
        end
    endtask : chk3
    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // All outputs against the reference; write-back data and address only judged when a write is expected
    task automatic check_all(input logic wen, input logic [6:0] wa, input logic [7:0] wd);
        chk8("w", ew, w_value);
        chk3("flags", ef, flags);
        chk3("wr_en", {2'b00, wen}, {2'b00, file_wr.en});
        if (wen) begin
            chk8("wr_data", wd, file_wr.data);
            chk8("wr_addr", {1'b0, wa}, {1'b0, file_wr.addr});
        end
        chk8("dir_a", ed[0], dir_a);
        chk8("dir_b", ed[1], dir_b);
        chk8("dir_c", ed[2], dir_c);
    endtask : check_all
    // One instruction at a falling edge; valid stays as given so back-to-back works
    task automatic step(input sxa_pkg::sxa_op_type op, input logic v, input logic [6:0] fa, input logic d,
        input logic [7:0] lit, input logic [7:0] frd);
        logic [8:0] bin;
        logic [7:0] res;
        logic wen;
        logic upd;
        instr = '{v, op, fa, d, lit};
        file_rd_data = frd;
        @(negedge clk);
        bin = (op == sxa_pkg::OP_SUB_W_FROM_FILE_BORROW) ? {8'h00, ~ef[2]} : 9'h000;
        res = 8'h00;
        wen = 1'b0;
        upd = 1'b0;
        if (v) begin
            case (op)
                // Carry set means no borrow, for both subtracts
                sxa_pkg::OP_SUB_W_FROM_FILE, sxa_pkg::OP_SUB_W_FROM_FILE_BORROW: begin
                    res = frd - ew - bin[7:0];
                    ef = {{1'b0, frd} >= {1'b0, ew} + bin, {5'h00, frd[3:0]} >= {5'h00, ew[3:0]} + bin, res == 8'h00};
                    upd = 1'b1;
                end
                sxa_pkg::OP_NIBBLE_EXCHANGE: begin
                    res = {frd[3:0], frd[7:4]};
                    upd = 1'b1;
                end
                sxa_pkg::OP_XOR_LITERAL_INTO_W: begin
                    res = ew ^ lit;
                    ef[0] = (res == 8'h00);
                    upd = 1'b1;
                end
                sxa_pkg::OP_XOR_W_WITH_FILE: begin
                    res = ew ^ frd;
                    ef[0] = (res == 8'h00);
                    upd = 1'b1;
                end
                // Only selectors 5..7 reach a direction register
                sxa_pkg::OP_DIRECTION_LOAD: begin
                    if (fa >= 7'h05 && fa <= 7'h07) ed[fa[1:0] - 2'd1] = ew;
                end
                default: ;
            endcase
            wen = upd && d && op != sxa_pkg::OP_XOR_LITERAL_INTO_W;
            if (upd && !wen) ew = res;
        end
        check_all(wen, fa, res);
    endtask : step
    // Reset held for a number of cycles, then reset values judged
    task automatic do_reset(input int cyc);
        rst_n = 1'b0;
        instr = '0;
        repeat (cyc) @(negedge clk);
        rst_n = 1'b1;
        ew = sxa_pkg::W_RESET;
        ef = 3'b000;
        ed = '{sxa_pkg::DIR_RESET, sxa_pkg::DIR_RESET, sxa_pkg::DIR_RESET};
        check_all(1'b0, 7'h00, 8'h00);
    endtask : do_reset
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_xor_lit();
        step(sxa_pkg::OP_XOR_LITERAL_INTO_W, 1'b1, 7'h7f, 1'b1, 8'h00, 8'h33);
        step(sxa_pkg::OP_XOR_LITERAL_INTO_W, 1'b1, 7'h00, 1'b0, 8'hff, 8'h00);
        step(sxa_pkg::OP_XOR_LITERAL_INTO_W, 1'b1, 7'h00, 1'b0, 8'ha5, 8'h00);
    endtask : t_xor_lit
    task automatic t_sub();
        step(sxa_pkg::OP_SUB_W_FROM_FILE, 1'b1, 7'h7f, 1'b1, 8'h00, 8'h5a);
        step(sxa_pkg::OP_SUB_W_FROM_FILE, 1'b1, 7'h00, 1'b0, 8'h00, 8'h59);
        step(sxa_pkg::OP_SUB_W_FROM_FILE, 1'b1, 7'h01, 1'b0, 8'h00, 8'hff);
    endtask : t_sub
    task automatic t_sub_borrow();
        step(sxa_pkg::OP_XOR_LITERAL_INTO_W, 1'b1, 7'h00, 1'b0, 8'h05, 8'h00);
        step(sxa_pkg::OP_SUB_W_FROM_FILE_BORROW, 1'b1, 7'h7f, 1'b0, 8'h00, 8'h13);
        step(sxa_pkg::OP_SUB_W_FROM_FILE_BORROW, 1'b1, 7'h11, 1'b1, 8'h00, 8'h0d);
        step(sxa_pkg::OP_SUB_W_FROM_FILE_BORROW, 1'b1, 7'h00, 1'b1, 8'h00, 8'h0f);
    endtask : t_sub_borrow
    task automatic t_swap_xor();
        step(sxa_pkg::OP_NIBBLE_EXCHANGE, 1'b1, 7'h22, 1'b1, 8'h00, 8'hc3);
        step(sxa_pkg::OP_NIBBLE_EXCHANGE, 1'b1, 7'h22, 1'b0, 8'h00, 8'ha1);
        step(sxa_pkg::OP_XOR_W_WITH_FILE, 1'b1, 7'h40, 1'b1, 8'h00, 8'h1a);
        step(sxa_pkg::OP_XOR_W_WITH_FILE, 1'b1, 7'h40, 1'b0, 8'h00, 8'hf0);
    endtask : t_swap_xor
    // Each selector, then a bad selector, a no-op, an undefined code and an idle cycle change nothing
    task automatic t_dir();
        for (int a = 5; a <= 7; a++) begin
            step(sxa_pkg::OP_XOR_LITERAL_INTO_W, 1'b1, 7'h00, 1'b0, {4'(a), 4'(a)} ^ ew, 8'h00);
            step(sxa_pkg::OP_DIRECTION_LOAD, 1'b1, 7'(a), 1'b0, 8'h00, 8'h00);
        end
        step(sxa_pkg::OP_DIRECTION_LOAD, 1'b1, 7'h04, 1'b1, 8'h00, 8'h00);
        step(sxa_pkg::OP_NONE, 1'b1, 7'h05, 1'b1, 8'h00, 8'h77);
        step(sxa_pkg::sxa_op_type'(3'h7), 1'b1, 7'h05, 1'b1, 8'hff, 8'h77);
        step(sxa_pkg::OP_XOR_LITERAL_INTO_W, 1'b0, 7'h05, 1'b1, 8'hff, 8'h77);
    endtask : t_dir
    // Reset in mid-run clears everything, then the first instruction is taken
    task automatic t_reset_again();
        do_reset(1);
        step(sxa_pkg::OP_XOR_LITERAL_INTO_W, 1'b1, 7'h00, 1'b1, 8'h3c, 8'h00);
    endtask : t_reset_again
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        file_rd_data = 8'h00;
        do_reset(20);
        t_xor_lit();
        t_sub();
        t_sub_borrow();
        t_swap_xor();
        t_dir();
        t_reset_again();
        conclude();
    end
    // About 50 cycles of work; a hang is cut far beyond that
    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule : tb_top
